// *** nfc_regs.vh ***
// Constants for the numeric format converter: opcodes, BCD layout, limits.
// Assumes inclusion by bare name from the converter's design files.
// ==========================================================================
`ifndef NFC_REGS_VH
`define NFC_REGS_VH
`define NFC_OP_W 3
`define NFC_OP_I16_BCD 3'h0
`define NFC_OP_I16_I32 3'h1
`define NFC_OP_BCD_I32 3'h2
`define NFC_OP_I32_BCD 3'h3
`define NFC_OP_I32_FLT 3'h4
`define NFC_OP_INV16 3'h5
`define NFC_MAX3 32'h000003E7
`define NFC_MAX7 32'h0098967F
`define NFC_SIGN_NEG 4'hF
`define NFC_SIGN_POS 4'h0
`define NFC_INV_MASK 16'hFFFF
`define NFC_EVENT_ID 16'h2521
`define NFC_RESET_RESULT 32'h00000000
`endif

// *** nfc_bin2bcd.v ***
// Combinational binary magnitude to seven BCD digits (double dabble).
// Assumes the caller limits the magnitude; larger values give wrapped digits.
`include "nfc_regs.vh"
module nfc_bin2bcd (
    input wire [31:0] mag_i,
    output reg [27:0] bcd_o
);
    integer i;
    reg [51:0] sh;
    // Shift-add-3; only 24 magnitude bits matter below 10,000,000
    always @* begin
        sh = 52'h0;
        sh[23:0] = mag_i[23:0];
        for (i = 0; i < 24; i = i + 1) begin
            if (sh[27:24] > 4'h4) sh[27:24] = sh[27:24] + 4'h3;
            if (sh[31:28] > 4'h4) sh[31:28] = sh[31:28] + 4'h3;
            if (sh[35:32] > 4'h4) sh[35:32] = sh[35:32] + 4'h3;
            if (sh[39:36] > 4'h4) sh[39:36] = sh[39:36] + 4'h3;
            if (sh[43:40] > 4'h4) sh[43:40] = sh[43:40] + 4'h3;
            if (sh[47:44] > 4'h4) sh[47:44] = sh[47:44] + 4'h3;
            if (sh[51:48] > 4'h4) sh[51:48] = sh[51:48] + 4'h3;
            sh = {sh[50:0], 1'b0};
        end
        bcd_o = sh[51:24];
    end
endmodule

// *** nfc_top.v ***
// Numeric format converter: one registered conversion per enabled cycle.
// Assumes operands are synchronous to mclk_i and the fault outputs feed the
// surrounding processor's stop and diagnostic logic.
//
// Conversions offered, selected by op_i:
//   int16 to three-digit decimal code, with overflow refusal
//   int16 widened to int32
//   seven-digit decimal code to int32, with bad-digit fault
//   int32 to seven-digit decimal code, with overflow refusal
//   int32 to single-precision float, truncating low mantissa bits
//   16-bit bit inversion
// Limitations the user must know:
//   - Every answer appears exactly one clock after the taking edge.
//   - A refused or faulting request leaves result_o as it was, so the
//     destination is never half written.
//   - The stop request is sticky; only reset clears it.
//   - Float conversion truncates, it does not round to nearest.
`include "nfc_regs.vh"
module nfc_top (
    input wire mclk_i,
    input wire rst_n_i,
    input wire enable_i,
    input wire [2:0] op_i,
    input wire [31:0] operand_i,
    input wire handler_present_i,
    output reg [31:0] result_o,
    output reg enable_out_o,
    output reg decimal_code_fault_o,
    output reg stop_req_o,
    output reg [15:0] diag_event_o,
    output reg diag_valid_o,
    output reg handler_call_o
);
    // ======================================================================
    // Helpers
    // Two's complement negate, shared by the magnitude and decimal paths
    function [31:0] nfc_neg;
        input [31:0] v;
        begin
            nfc_neg = ~v + 32'h00000001;
        end
    endfunction

    // Sign nibble of a decimal-code word: all ones negative, zeros positive
    function [3:0] nfc_sign_nib;
        input neg;
        begin
            nfc_sign_nib = neg ? `NFC_SIGN_NEG : `NFC_SIGN_POS;
        end
    endfunction

    // Magnitude of a signed 32-bit value, kept 32 bits wide
    // The most negative value maps to itself; the decimal path refuses it as overflow, the float path reads it as 2^31
    function [31:0] nfc_abs;
        input [31:0] v;
        begin
            nfc_abs = v[31] ? nfc_neg(v) : v;
        end
    endfunction

    // True when any of the seven low nibbles holds 10..15
    function nfc_bad_digit;
        input [27:0] d;
        integer k;
        begin
            nfc_bad_digit = 1'b0;
            for (k = 0; k < 7; k = k + 1) begin
                if (d[4*k+3 -: 4] > 4'h9) nfc_bad_digit = 1'b1;
            end
        end
    endfunction

    // Signed int32 to IEEE single, truncating extra mantissa bits
    function [31:0] nfc_to_float;
        input [31:0] v;
        reg [31:0] m;
        reg [7:0] e;
        integer p, j;
        begin
            m = nfc_abs(v);
            p = 0;
            for (j = 0; j < 32; j = j + 1) begin
                if (m[j]) p = j;
            end
            if (m == 32'h0) begin
                nfc_to_float = 32'h00000000;
            end else begin
                e = p[7:0] + 8'h7F;
                m = m << (31 - p);
                nfc_to_float = {v[31], e, m[30:8]};
            end
        end
    endfunction

    // Weighted sum of seven decimal digits, most significant nibble first
    function [31:0] nfc_bcd_value;
        input [27:0] d;
        reg [31:0] a;
        integer k;
        begin
            a = 32'h00000000;
            for (k = 6; k >= 0; k = k - 1) begin
                // Times ten as two shifts keeps a multiplier out of the path
                a = (a << 3) + (a << 1) + {28'h0000000, d[4*k+3 -: 4]};
            end
            nfc_bcd_value = a;
        end
    endfunction

    // ======================================================================
    // Datapath
    wire [31:0] wide = {{16{operand_i[15]}}, operand_i[15:0]};
    wire [31:0] mag16 = nfc_abs(wide);
    wire [31:0] mag32 = nfc_abs(operand_i);
    wire [31:0] bin_mag = (op_i == `NFC_OP_I16_BCD) ? mag16 : mag32;
    wire [27:0] digits;
    reg [31:0] result_next;
    reg enable_out_next;
    reg fault_next;
    reg [31:0] acc;

    nfc_bin2bcd u_bin2bcd (
        .mag_i(bin_mag),
        .bcd_o(digits)
    );

    // Select one conversion; a disabled or faulting cycle keeps the result
    always @* begin
        result_next = result_o;
        enable_out_next = 1'b0;
        fault_next = 1'b0;
        acc = 32'h0;
        if (enable_i) begin
            case (op_i)
                // Three digits only; upper half of the word stays zero
                `NFC_OP_I16_BCD: begin
                    enable_out_next = (mag16 <= `NFC_MAX3);
                    if (enable_out_next) begin
                        result_next = {16'h0000,
                            nfc_sign_nib(wide[31]),
                            digits[11:0]};
                    end
                end
                // Plain sign extension, never refused
                `NFC_OP_I16_I32: begin
                    result_next = wide;
                    enable_out_next = 1'b1;
                end
                // Bad digits leave the destination as it was
                `NFC_OP_BCD_I32: begin
                    enable_out_next = 1'b1;
                    fault_next = nfc_bad_digit(operand_i[27:0]);
                    acc = nfc_bcd_value(operand_i[27:0]);
                    if (!fault_next) begin
                        result_next = (operand_i[31:28] == `NFC_SIGN_NEG) ?
                            nfc_neg(acc) : acc;
                    end
                end
                // Seven digits plus the sign nibble fill the whole word
                `NFC_OP_I32_BCD: begin
                    enable_out_next = (mag32 <= `NFC_MAX7);
                    if (enable_out_next) begin
                        result_next = {nfc_sign_nib(operand_i[31]),
                            digits};
                    end
                end
                // Every int32 has a float, so this path is never refused
                `NFC_OP_I32_FLT: begin
                    result_next = nfc_to_float(operand_i);
                    enable_out_next = 1'b1;
                end
                // Upper half cleared rather than inverted
                `NFC_OP_INV16: begin
                    result_next = {16'h0000, operand_i[15:0] ^ `NFC_INV_MASK};
                    enable_out_next = 1'b1;
                end
                default: begin
                    enable_out_next = 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Registers
    // Result and enable out take the selected conversion on every edge
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o <= `NFC_RESET_RESULT;
            enable_out_o <= 1'b0;
        end else begin
            result_o <= result_next;
            enable_out_o <= enable_out_next;
        end
    end

    // Fault reporting: pulses last one cycle per faulting request
    // Stop request is sticky: only reset brings the processor out of stop
    // The event code is left standing so software can read it after stop
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            decimal_code_fault_o <= 1'b0;
            stop_req_o <= 1'b0;
            diag_event_o <= 16'h0000;
            diag_valid_o <= 1'b0;
            handler_call_o <= 1'b0;
        end else begin
            decimal_code_fault_o <= fault_next;
            stop_req_o <= stop_req_o | fault_next;
            diag_valid_o <= fault_next;
            if (fault_next) diag_event_o <= `NFC_EVENT_ID;
            handler_call_o <= fault_next & handler_present_i;
        end
    end
endmodule

// *** nfc_top_sva.sv ***
// Checker for the numeric format converter, ports of nfc_top only.
// Assumes one clock mclk_i and the asynchronous active-low reset rst_n_i.
// ==========================================
// Port relations one cycle after each taken request
module nfc_chk (
    input wire mclk_i,
    input wire rst_n_i,
    input wire enable_i,
    input wire [2:0] op_i,
    input wire [31:0] operand_i,
    input wire handler_present_i,
    input wire [31:0] result_o,
    input wire enable_out_o,
    input wire decimal_code_fault_o,
    input wire stop_req_o,
    input wire [15:0] diag_event_o,
    input wire diag_valid_o,
    input wire handler_call_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Idle cycles must leave the destination alone
    a_idle_hold: assert property (!enable_i |=> !enable_out_o && $stable(result_o))
        else $error("Idle cycle moved enable out or result");
    a_wide_val: assert property (enable_i && op_i == 3'h1 |=> enable_out_o &&
        result_o == {{16{$past(operand_i[15])}}, $past(operand_i[15:0])})
        else $error("Widened value wrong");
    a_inv_val: assert property (enable_i && op_i == 3'h5 |=> enable_out_o &&
        result_o == {16'h0, ~$past(operand_i[15:0])}) else $error("Inverted value wrong");
    a_flt_eno: assert property (enable_i && op_i == 3'h4 |=> enable_out_o)
        else $error("Float path dropped enable out");
    a_bcd_eno: assert property (enable_i && op_i == 3'h2 |=> enable_out_o)
        else $error("Decimal path dropped enable out");
    // Magnitude above 999 either way is an overflow
    a_ovf_three: assert property (enable_i && op_i == 3'h0 && (operand_i[15] ?
        operand_i[15:0] < 16'hFC19 : operand_i[15:0] > 16'h03E7) |=> !enable_out_o)
        else $error("Three digit overflow not refused");
    a_sign_nib: assert property (enable_i && op_i == 3'h3 && operand_i[31] &&
        operand_i >= 32'hFF676981 |=> result_o[31:28] == 4'hF) else $error("Sign nibble wrong");
    a_fault_log: assert property (decimal_code_fault_o |-> stop_req_o && diag_valid_o &&
        diag_event_o == 16'h2521) else $error("Fault not logged");
    a_handler: assert property (decimal_code_fault_o |->
        handler_call_o == $past(handler_present_i)) else $error("Handler call wrong");
endmodule
bind nfc_top nfc_chk i_chk (.*);

// *** testbench.sv ***
// Self-checking bench for nfc_top with a behavioural model per request.
// Assumes nfc_top answers exactly one cycle after the taking edge.
// ==========================================
// Bench, model and random stimulus
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rst_n_i = 0, enable_i = 0, handler_present_i = 0;
    logic [2:0] op_i = 0;
    logic [31:0] operand_i = 0, result_o, r = 15319, res_e = 0;
    logic enable_out_o, decimal_code_fault_o, stop_req_o, diag_valid_o, handler_call_o;
    logic [15:0] diag_event_o;
    logic eno_e = 0, flt_e = 0, stp_e = 0, hc_e = 0;
    int err_total = 0, samples_checked = 0;
    nfc_top i_nfc_top (.*);
    always #4 mclk_i = ~mclk_i;
    function automatic logic [31:0] nx(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [27:0] bcd(longint m);
        for (int k = 0; k < 7; k++) begin
            bcd[4*k+:4] = 4'(m % 10);
            m = m / 10;
        end
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
            err_total++;
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Model keeps the last result, since refusals and faults hold it
    task automatic model(logic en, logic [2:0] op, logic [31:0] v, logic hp);
        longint s;
        logic [63:0] d;
        logic [10:0] e;
        eno_e = 0;
        flt_e = 0;
        s = (op < 2 || op == 5) ? longint'($signed(v[15:0])) : longint'($signed(v));
        if (en) case (op)
            3'h0, 3'h3: if ((s < 0 ? -s : s) <= (op == 0 ? 999 : 9999999)) begin
                eno_e = 1;
                res_e = {s < 0 ? 4'hF : 4'h0, bcd(s < 0 ? -s : s)};
                if (op == 0) res_e = {16'h0, res_e[31:28], res_e[11:0]};
            end
            3'h1: {eno_e, res_e} = {1'b1, 32'(s)};
            3'h2: begin
                eno_e = 1;
                s = 0;
                for (int k = 6; k >= 0; k--) begin
                    flt_e |= v[4*k+:4] > 9;
                    s = s * 10 + v[4*k+:4];
                end
                if (!flt_e) res_e = 32'(v[31:28] == 4'hF ? -s : s);
            end
            // Truncating the double mantissa gives the truncated single
            3'h4: begin
                eno_e = 1;
                d = $realtobits(real'(s));
                e = d[62:52] - 11'd896;
                res_e = v == 0 ? 32'h0 : {d[63], e[7:0], d[51:29]};
            end
            3'h5: {eno_e, res_e} = {1'b1, 16'h0, ~v[15:0]};
            default: ;
        endcase
        stp_e |= flt_e;
        hc_e = flt_e & hp;
    endtask
    initial begin
        logic [2:0] op;
        logic [31:0] v;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1;
        for (int i = 0; i < 3000; i++) begin
            @(posedge mclk_i);
            r = nx(r);
            op = r[2:0];
            v = nx(r ^ 32'h5A5A);
            if (op == 0) v = 32'(int'(r[31:8] % 2100) - 1050);
            if (op == 3) v = 32'(int'(r[31:7] % 24000000) - 12000000);
            if (op == 2) v = {r[31] ? 4'hF : r[30:27], bcd(v[23:0]) | (r[26:24] == 0 ? 28'hA0 : 0)};
            enable_i <= r[3] | r[4];
            op_i <= op;
            operand_i <= v;
            handler_present_i <= r[5];
            #1;
            chk(result_o, res_e);
            chk({enable_out_o, decimal_code_fault_o, diag_valid_o}, {eno_e, flt_e, flt_e});
            chk({stop_req_o, handler_call_o, diag_event_o}, {stp_e, hc_e, stp_e ? 16'h2521 : 16'h0});
            model(enable_i, op_i, operand_i, handler_present_i);
        end
        tally_and_finish();
    end
endmodule
